// File: logic/wdt_pkg.sv
package wdt_pkg;
  // bus register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] stat_off = 8'h04;
  localparam logic [7:0] mask_off = 8'h08;
  localparam logic [7:0] core_off = 8'h0C;
  localparam logic [7:0] cfg_off = 8'h10;
  // control register layout
  localparam int ctrl_w = 8;
  localparam int ps_lsb = 1;
  localparam int ps_msb = 5;
  localparam int swen_bit = 0;
  localparam logic [7:0] ctrl_reset = 8'h16;
  localparam logic [7:0] ctrl_wmask = 8'h3F;
  // period select
  localparam logic [4:0] ps_max = 5'h12;
  localparam logic [4:0] ps_min = 5'h00;
  localparam int base_shift = 5;
  localparam int cnt_w = 24;
  // mode field encodings
  localparam logic [1:0] mode_off = 2'h0;
  localparam logic [1:0] mode_sw = 2'h1;
  localparam logic [1:0] mode_awake = 2'h2;
  localparam logic [1:0] mode_on = 2'h3;
  // status bits
  localparam int ev_w = 2;
  localparam int ev_wake = 0;
  localparam int ev_rst = 1;
  localparam int to_bit = 0;
  localparam int pd_bit = 1;
  // config register layout
  localparam int mode_lsb = 0;
  localparam int mode_msb = 1;
  localparam int xtal_bit = 2;
  localparam logic [2:0] cfg_reset = 3'h0;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [1:0] htrans_seq = 2'h3;
endpackage

// File: logic/sync3.sv
`timescale 1ns/1ps
module sync3
  import wdt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic d,
  output logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else if (ce)
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // one-cycle rise while stage two is high and stage three still low
  assign rise = ce && s2_q && !s3_q;
endmodule

// File: logic/wdt_sleep_ctl.sv
`timescale 1ns/1ps
// Behaviour
// - entering sleep clears the counter; it restarts from zero if still enabled
// - leaving sleep clears the counter again, whatever the clock source
// - crystal modes hold the counter clear until oscillator start-up ends
// - time-out during sleep wakes the device instead of resetting it
// - a time-out clears the timeout flag; only a time-out during sleep also clears the powerdown flag
// - mode 00, or 01 with software enable low, holds the counter clear
// - mode 10 clears and stops the counter for the whole sleep
// - writing the oscillator divider field leaves the counter untouched
// - any reset, clear instruction, oscillator failure or disable clears it
// - period spans 1 ms to 256 s, doubling; reset default two seconds
// - software enable acts only in mode 01
// - mode 11 always active; mode 10 active only awake
module wdt_sleep_ctl
  import wdt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic lf_osc,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic watchdog_clear_instruction,
  input wire logic osc_fail,
  input wire logic ost_done,
  input wire logic divider_write,
  output logic sleeping,
  output logic sys_reset_req,
  output logic wake_out,
  output logic irq
);
  logic [7:0] ctrl_q;
  logic [2:0] cfg_q;
  logic [ev_w-1:0] stat_q;
  logic [ev_w-1:0] mask_q;
  logic timeout_flag_q;
  logic powerdown_flag_q;
  logic [cnt_w-1:0] cnt_q;
  logic sleeping_q;
  logic ost_hold_q;
  logic rst_req_q;
  logic wake_q;
  logic irq_q;
  logic [31:0] rdata_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic readyout_q;
  logic resp_q;
  logic tick;

  sync3 u_tick (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .d(lf_osc),
    .rise(tick)
  );

  // terminal count for a period code
  function automatic logic [cnt_w-1:0] term_count(input logic [4:0] code);
    logic [4:0] eff;
    eff = code;
    if (code > ps_max)
      eff = ps_min;
    term_count = cnt_w'(1) << (eff + 5'(base_shift));
  endfunction

  wire logic [1:0] watchdog_mode_field = cfg_q[mode_msb:mode_lsb];
  wire logic crystal_clock = cfg_q[xtal_bit];
  wire logic software_watchdog_enable = ctrl_q[swen_bit];
  wire logic [4:0] period_select = ctrl_q[ps_msb:ps_lsb];

  wire logic active =
    (watchdog_mode_field == mode_on) ||
    (watchdog_mode_field == mode_awake && !sleeping_q) ||
    (watchdog_mode_field == mode_sw && software_watchdog_enable);

  wire logic enter_sleep = sleep_req && !sleeping_q;
  wire logic wake_evt = wake_req && sleeping_q;
  wire logic terminal = active && tick && !ost_hold_q &&
    (cnt_q + cnt_w'(1) >= term_count(period_select));
  wire logic to_sleep = terminal && sleeping_q;
  wire logic to_awake = terminal && !sleeping_q;
  wire logic leave_sleep = wake_evt || to_sleep;

  wire logic clr = watchdog_clear_instruction || osc_fail || !active ||
    enter_sleep || leave_sleep || ost_hold_q;

  // bus decode
  wire logic addr_phase = hsel && hready && htrans[1];
  wire logic wr_ctrl = wr_pend_q && wr_addr_q == ctrl_off;
  wire logic wr_stat = wr_pend_q && wr_addr_q == stat_off;
  wire logic wr_mask = wr_pend_q && wr_addr_q == mask_off;
  wire logic wr_cfg = wr_pend_q && wr_addr_q == cfg_off;
  wire logic [7:0] ra = haddr[7:0];
  wire logic [31:0] rd_mux =
    (ra == ctrl_off) ? {24'h0, ctrl_q} :
    (ra == stat_off) ? {30'h0, stat_q} :
    (ra == mask_off) ? {30'h0, mask_q} :
    (ra == core_off) ? {30'h0, powerdown_flag_q, timeout_flag_q} :
    (ra == cfg_off) ? {29'h0, cfg_q} : 32'h0;
  wire logic [ev_w-1:0] ev_set = {to_awake, to_sleep};
  wire logic [ev_w-1:0] stat_d =
    ev_set | (stat_q & ~(wr_stat ? hwdata[ev_w-1:0] : 2'h0));

  // zero wait states, always an okay response
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      readyout_q <= 1'b1;
      resp_q <= 1'b0;
    end
    else if (ce)
    begin
      readyout_q <= 1'b1;
      resp_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0;
    end
    else if (ce)
    begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= ra;
      if (addr_phase && !hwrite)
        rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q <= ctrl_reset;
      cfg_q <= cfg_reset;
      mask_q <= '0;
      stat_q <= '0;
    end
    else if (ce)
    begin
      if (wr_ctrl)
        ctrl_q <= hwdata[7:0] & ctrl_wmask;
      if (wr_cfg)
        cfg_q <= hwdata[2:0];
      if (wr_mask)
        mask_q <= hwdata[ev_w-1:0];
      stat_q <= stat_d;
    end
  end

  // counter
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= '0;
    else if (ce)
    begin
      if (clr || terminal)
        cnt_q <= '0;
      else if (tick)
        cnt_q <= cnt_q + cnt_w'(1);
    end
  end

  // sleep state and start-up hold
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sleeping_q <= 1'b0;
      ost_hold_q <= 1'b0;
    end
    else if (ce)
    begin
      if (enter_sleep)
        sleeping_q <= 1'b1;
      else if (leave_sleep)
        sleeping_q <= 1'b0;
      if (leave_sleep && crystal_clock)
        ost_hold_q <= 1'b1;
      else if (ost_done)
        ost_hold_q <= 1'b0;
    end
  end

  // flags and outputs
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      timeout_flag_q <= 1'b1;
      powerdown_flag_q <= 1'b1;
      rst_req_q <= 1'b0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      if (terminal)
        timeout_flag_q <= 1'b0;
      else if (watchdog_clear_instruction)
        timeout_flag_q <= 1'b1;
      if (enter_sleep || to_sleep)
        powerdown_flag_q <= 1'b0;
      else if (watchdog_clear_instruction)
        powerdown_flag_q <= 1'b1;
      rst_req_q <= to_awake;
      wake_q <= to_sleep;
      irq_q <= |(stat_d & mask_q);
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = readyout_q;
  assign hresp = resp_q;
  assign sleeping = sleeping_q;
  assign sys_reset_req = rst_req_q;
  assign wake_out = wake_q;
  assign irq = irq_q;
endmodule

// File: test/wdt_monitor.sv
`timescale 1ns/1ps
module wdt_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic sleeping,
  input wire logic sys_reset_req,
  input wire logic wake_out
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence go_s;
    sleep_req && ce && !sleeping;
  endsequence
  okay_resp_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  sleep_entry_a: assert property (go_s |=> sleeping)
    else $error("sleep request ignored");
  sleep_cause_a: assert property ($rose(sleeping) |-> $past(sleep_req))
    else $error("sleep without request");
  wake_exit_a: assert property
    (wake_req && ce && sleeping |=> !sleeping)
    else $error("wake request ignored");
  sleep_noreset_a: assert property
    (sleeping && $past(sleeping) |-> !sys_reset_req)
    else $error("reset while asleep");
  wake_cause_a: assert property (wake_out |-> $past(sleeping))
    else $error("wake pulse while awake");
  wake_leave_a: assert property (wake_out |-> ##[0:2] !sleeping)
    else $error("wake pulse left device asleep");
  reset_pulse_a: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than a pulse");
endmodule
bind wdt_sleep_ctl wdt_monitor mon (.mclk(mclk), .rst_b(rst_b), .ce(ce),
  .hreadyout(hreadyout), .hresp(hresp), .sleep_req(sleep_req),
  .wake_req(wake_req), .sleeping(sleeping),
  .sys_reset_req(sys_reset_req), .wake_out(wake_out));

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  import wdt_pkg::*;
  logic mclk = 0, rst_b = 0, ce = 1, hsel = 0, hwrite = 0, lf = 0, oscillator_startup_timer = 0;
  logic slq = 0, wkq = 0, hreadyout, hresp, sleeping, sys_reset_req;
  logic wake_out, irq;
  logic [2:0] ev = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
  int num_errors, comparisons, rs, ws, rsts, wakes, seed = 3084;
  int mode, code, swen, slp, cnt, xt, hold, core;
  always #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    rs += sys_reset_req;
    ws += wake_out;
  end
  wdt_sleep_ctl uut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .lf_osc(lf), .sleep_req(slq),
    .wake_req(wkq), .watchdog_clear_instruction(ev[0]), .osc_fail(ev[1]),
    .ost_done(oscillator_startup_timer), .divider_write(ev[2]), .sleeping(sleeping),
    .sys_reset_req(sys_reset_req), .wake_out(wake_out), .irq(irq));
  task chk(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task xf(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1;
    htrans <= htrans_nonseq;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    xf(0, a, 32'h0);
    chk($sformatf("reg %h", a), rv, e);
  endtask
  task pe(int i);
    ev <= 3'h1 << i;
    @(posedge mclk);
    ev <= 3'h0;
    repeat (3) @(posedge mclk);
    if (i < 2) cnt = 0;
    if (i == 0) core = 3;
  endtask
  task cf(int m, int c, int s);
    xf(1, cfg_off, m);
    xf(1, ctrl_off, c << 1 | s);
    xt = m / 4;
    mode = m % 4;
    code = c;
    swen = s;
    pe(0);
  endtask
  task sw(int w);
    slq <= !w;
    wkq <= w;
    @(posedge mclk);
    slq <= 0;
    wkq <= 0;
    repeat (3) @(posedge mclk);
    slp = !w;
    cnt = 0;
    hold = w && xt;
  endtask
  // model: n low-frequency ticks, each counted when enabled
  task tk(int n);
    repeat (n)
    begin
      lf <= 1;
      repeat (4) @(posedge mclk);
      lf <= 0;
      repeat (4) @(posedge mclk);
      if (!hold && (mode == 3 || mode == 2 && !slp || mode == 1 && swen))
        cnt++;
      if (cnt == 32 << (code > 18 ? 0 : code))
      begin
        cnt = 0;
        core = slp ? 0 : 2;
        if (slp) wakes++;
        else rsts++;
        slp = 0;
      end
    end
    chk("resets", rs, rsts);
    chk("wakes", ws, wakes);
    chk("sleeping", sleeping, slp);
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    rd(ctrl_off, 32'h16);
    rd(core_off, 32'h3);
    rd(8'h20, 32'h0);
    xf(1, ctrl_off, 32'hFF);
    rd(ctrl_off, 32'h3F);
    cf(3, 0, 0);
    tk(31);
    tk(1);
    rd(core_off, 32'h2);
    xf(1, mask_off, 32'h3);
    rd(stat_off, 32'h2);
    chk("irq", irq, 1);
    xf(1, stat_off, 32'h2);
    repeat (2) @(posedge mclk);
    chk("irq", irq, 0);
    $display("test awake time-out done");
    cf(3, 19 + {$random(seed)} % 13, 0);
    tk(32);
    for (int i = 0; i < 3; i++)
    begin
      cf(3, 0, 0);
      tk(20);
      pe(i);
      tk(20);
      tk(12);
    end
    for (int i = 0; i < 4; i++)
    begin
      cf(i / 2, 0, i % 2);
      tk(32);
    end
    $display("test clears and modes done");
    cf(3, 0, 0);
    tk(10);
    sw(0);
    tk(32);
    rd(core_off, 32'h0);
    cf(2, 0, 0);
    tk(10);
    sw(0);
    tk(40);
    sw(1);
    tk(32);
    cf(7, 0, 0);
    sw(0);
    sw(1);
    tk(40);
    oscillator_startup_timer <= 1;
    hold = 0;
    tk(32);
    $display("test sleep done");
    conclude();
  end
endmodule
